// *** rtl/ubs_pkg.sv ***
// Constants shared by the serial rate and mode 0 shift logic.
// Assumes one CPU clock per state, six states to a machine cycle.
package ubs_pkg;
    // ----------------------------------------
    // Register byte offsets on the bus
    // ----------------------------------------
    localparam logic [4:0] OFS_SERIAL_BUFFER = 5'h00;
    localparam logic [4:0] OFS_SERIAL_CONTROL = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_POWER_CONTROL = 5'h0c;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
    localparam logic [4:0] OFS_TIMER_MODE = 5'h14;
    localparam logic [4:0] OFS_TIMER_LOW = 5'h18;
    localparam logic [4:0] OFS_TIMER_HIGH = 5'h1c;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTL_MODE_LO = 0;    // Serial mode, bits 1:0
    localparam int CTL_RX_EN = 4;      // Receive enable
    localparam int CTL_TIMER_RUN = 6;  // Timer 1 run
    localparam int STS_TX_DONE = 0;    // Transmit done, write one to clear
    localparam int STS_RX_DONE = 1;    // Receive done, write one to clear
    localparam int PWR_RATE_DOUBLE = 7;
    localparam int TMD_GATE = 7;
    localparam int TMD_COUNTER = 6;
    localparam int TMD_MODE_LO = 4;    // Timer mode, bits 5:4

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_MODE = 8'h20;   // Timer, auto-reload
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [7:0] RX_INIT_PATTERN = 8'hfe;

    // ----------------------------------------
    // Timing counts in CPU clocks and states
    // ----------------------------------------
    localparam int STATES_PER_CYCLE = 6;
    localparam logic [2:0] ST_S1 = 3'h0;
    localparam logic [2:0] ST_S3 = 3'h2;
    localparam logic [2:0] ST_S5 = 3'h4;
    localparam logic [2:0] ST_S6 = 3'h5;
    localparam logic [4:0] DIV_SLOW_LAST = 5'h1f;  // Divide by 32
    localparam logic [4:0] DIV_FAST_LAST = 5'h0f;  // Divide by 16

    typedef enum logic [1:0] {UBS_MODE0, UBS_MODE1, UBS_MODE2, UBS_MODE3} ubs_mode_t;
endpackage

// *** rtl/ubs_uart_baud.sv ***
// Serial port rate generation and mode 0 synchronous shift engine.
// Assumes an Avalon-MM master on clk_sys_in, and pins synchronised here.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ubs_uart_baud (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic port_line_data_in,
    output logic port_line_data_out,
    output logic port_line_data_oe_out,
    output logic port_line_clock_out,
    input wire logic timer_count_pin_in,
    input wire logic timer_gate_pin_in,
    output logic baud_tick_out,
    output logic irq_out
);
    import ubs_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] serial_control_reg_q;
    logic [7:0] power_control_reg_q;
    logic [7:0] timer_mode_reg_q;
    logic [7:0] timer_low_byte_q;
    logic [7:0] timer_high_byte_q;
    logic [1:0] irq_mask_q;
    logic transmit_done_flag_q;
    logic receive_done_flag_q;
    logic [7:0] serial_buffer_rx_q;
    logic [31:0] readdata_q;
    logic waitreq_q;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic lane0;
    logic rate_double;
    ubs_mode_t mode;

    assign bus_req = avs_read_in | avs_write_in;
    assign bus_wr = avs_write_in & ~waitreq_q;
    assign bus_rd = avs_read_in & ~waitreq_q;
    assign lane0 = avs_byteenable_in[0];
    assign rate_double = power_control_reg_q[PWR_RATE_DOUBLE];
    assign mode = ubs_mode_t'(serial_control_reg_q[CTL_MODE_LO +: 2]);

    // Decode used by every register write
    function automatic logic wr_hit(input logic [4:0] ofs);
        wr_hit = bus_wr && lane0 && (avs_address_in == ofs);
    endfunction

    // ----------------------------------------
    // Bus slave: one wait state
    // ----------------------------------------
    // Waitrequest low one cycle after a request
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            waitreq_q <= 1'b1;
        end else begin
            waitreq_q <= ~(bus_req & waitreq_q);
        end
    end

    // Read data caught early, stands at taking edge
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            readdata_q <= 32'h0;
        end else if (avs_read_in && waitreq_q) begin
            unique case (avs_address_in)
                OFS_SERIAL_BUFFER: readdata_q <= {24'h0, serial_buffer_rx_q};
                OFS_SERIAL_CONTROL: readdata_q <= {24'h0, serial_control_reg_q};
                OFS_STATUS: readdata_q <= {30'h0, receive_done_flag_q, transmit_done_flag_q};
                OFS_POWER_CONTROL: readdata_q <= {24'h0, power_control_reg_q};
                OFS_IRQ_MASK: readdata_q <= {30'h0, irq_mask_q};
                OFS_TIMER_MODE: readdata_q <= {24'h0, timer_mode_reg_q};
                OFS_TIMER_LOW: readdata_q <= {24'h0, timer_low_byte_q};
                OFS_TIMER_HIGH: readdata_q <= {24'h0, timer_high_byte_q};
                default: readdata_q <= 32'h0;  // Unmapped reads as zero
            endcase
        end
    end

    // Plain control registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            serial_control_reg_q <= RST_SERIAL_CONTROL;
            power_control_reg_q <= RST_POWER_CONTROL;
            timer_mode_reg_q <= RST_TIMER_MODE;
            irq_mask_q <= RST_IRQ_MASK;
        end else begin
            if (wr_hit(OFS_SERIAL_CONTROL)) begin
                serial_control_reg_q <= avs_writedata_in[7:0];
            end
            if (wr_hit(OFS_POWER_CONTROL)) begin
                power_control_reg_q <= avs_writedata_in[7:0];
            end
            if (wr_hit(OFS_TIMER_MODE)) begin
                timer_mode_reg_q <= avs_writedata_in[7:0];
            end
            if (wr_hit(OFS_IRQ_MASK)) begin
                irq_mask_q <= avs_writedata_in[1:0];
            end
        end
    end

    // ----------------------------------------
    // Machine cycle sequencer, S1..S6 one clock each
    // ----------------------------------------
    logic [2:0] state_q;
    logic at_s1;
    logic at_s5;
    logic at_s6;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_q <= ST_S1;
        end else if (state_q == ST_S6) begin
            state_q <= ST_S1;
        end else begin
            state_q <= state_q + 3'h1;
        end
    end
    assign at_s1 = (state_q == ST_S1);
    assign at_s5 = (state_q == ST_S5);
    assign at_s6 = (state_q == ST_S6);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] data_sync_q;
    logic [1:0] count_sync_q;
    logic [1:0] gate_sync_q;
    logic count_prev_q;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            data_sync_q <= 2'b11;
            count_sync_q <= 2'b11;
            gate_sync_q <= 2'b11;
            count_prev_q <= 1'b1;
        end else begin
            data_sync_q <= {data_sync_q[0], port_line_data_in};
            count_sync_q <= {count_sync_q[0], timer_count_pin_in};
            gate_sync_q <= {gate_sync_q[0], timer_gate_pin_in};
            count_prev_q <= count_sync_q[1];
        end
    end

    // ----------------------------------------
    // Timer 1
    // ----------------------------------------
    logic t1_run;
    logic t1_inc;
    logic t1_ovf;
    logic [1:0] t1_mode;

    assign t1_mode = timer_mode_reg_q[TMD_MODE_LO +: 2];
    assign t1_run = serial_control_reg_q[CTL_TIMER_RUN]
                    & (~timer_mode_reg_q[TMD_GATE] | gate_sync_q[1])
                    & (t1_mode != 2'h3);  // Mode 3 holds the timer
    // timer or counter source; counter takes falling pin edges
    assign t1_inc = t1_run & (timer_mode_reg_q[TMD_COUNTER] ? (count_prev_q & ~count_sync_q[1]) : at_s6);

    // Overflow in each running mode
    always_comb begin
        unique case (t1_mode)
            2'h0: t1_ovf = t1_inc && (timer_high_byte_q == 8'hff) && (timer_low_byte_q[4:0] == 5'h1f);
            2'h1: t1_ovf = t1_inc && (timer_high_byte_q == 8'hff) && (timer_low_byte_q == 8'hff);
            2'h2: t1_ovf = t1_inc && (timer_low_byte_q == 8'hff);
            2'h3: t1_ovf = 1'b0;
        endcase
    end

    // Counting; a bus write to a byte wins over the count
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            timer_low_byte_q <= 8'h00;
            timer_high_byte_q <= 8'h00;
        end else begin
            if (t1_inc) begin
                unique case (t1_mode)
                    2'h0: begin
                        timer_low_byte_q <= {3'h0, timer_low_byte_q[4:0] + 5'h01};
                        if (timer_low_byte_q[4:0] == 5'h1f) begin
                            timer_high_byte_q <= timer_high_byte_q + 8'h01;
                        end
                    end
                    2'h1: begin
                        timer_low_byte_q <= timer_low_byte_q + 8'h01;
                        if (timer_low_byte_q == 8'hff) begin
                            timer_high_byte_q <= timer_high_byte_q + 8'h01;
                        end
                    end
                    // reload low from high, high kept
                    2'h2: timer_low_byte_q <= t1_ovf ? timer_high_byte_q : timer_low_byte_q + 8'h01;
                    2'h3: timer_low_byte_q <= timer_low_byte_q;
                endcase
            end
            if (wr_hit(OFS_TIMER_LOW)) begin
                timer_low_byte_q <= avs_writedata_in[7:0];
            end
            if (wr_hit(OFS_TIMER_HIGH)) begin
                timer_high_byte_q <= avs_writedata_in[7:0];
            end
        end
    end

    // ----------------------------------------
    // Bit rate tick for the framed modes
    // ----------------------------------------
    logic [4:0] div_q;
    logic div_step;
    logic [4:0] div_last;
    logic div_wrap;

    // mode 2 counts clocks; modes 1,3 count overflows
    assign div_step = (mode == UBS_MODE2) ? 1'b1 : (mode != UBS_MODE0) & t1_ovf;
    // divide by 32, or 16 when doubled
    assign div_last = rate_double ? DIV_FAST_LAST : DIV_SLOW_LAST;
    assign div_wrap = div_step && (div_q >= div_last);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            div_q <= 5'h00;
            baud_tick_out <= 1'b0;
        end else begin
            if (div_step) begin
                div_q <= div_wrap ? 5'h00 : div_q + 5'h01;
            end
            // mode 0 ticks every machine cycle
            baud_tick_out <= (mode == UBS_MODE0) ? at_s6 : div_wrap;
        end
    end

    // ----------------------------------------
    // Mode 0 transmit
    // ----------------------------------------
    logic tx_pend_q;
    logic tx_arm_q;
    logic tx_arm2_q;
    logic send_q;
    logic [8:0] tx_shift_q;
    logic tx_finish;
    logic buf_wr;

    // buffer write loads the transmit side
    assign buf_wr = wr_hit(OFS_SERIAL_BUFFER);
    // only the marker left: shifts done
    assign tx_finish = at_s1 && send_q && (tx_shift_q == 9'h001);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            tx_pend_q <= 1'b0;
            tx_arm_q <= 1'b0;
            tx_arm2_q <= 1'b0;
            send_q <= 1'b0;
            tx_shift_q <= 9'h000;
        end else begin
            if (buf_wr && mode == UBS_MODE0) begin
                tx_pend_q <= 1'b1;
                tx_shift_q <= {1'b1, avs_writedata_in[7:0]};
            end else if (at_s6 && tx_pend_q) begin
                // taken at S6, ninth bit marker in place
                tx_pend_q <= 1'b0;
                tx_arm_q <= 1'b1;
            end else if (at_s6 && send_q) begin
                tx_shift_q <= {1'b0, tx_shift_q[8:1]};
            end
            // one whole machine cycle before send
            if (at_s6 && tx_arm_q && !tx_pend_q) begin
                tx_arm_q <= 1'b0;
                tx_arm2_q <= 1'b1;
            end
            if (at_s1 && tx_arm2_q) begin
                tx_arm2_q <= 1'b0;
                send_q <= 1'b1;
            end else if (tx_finish) begin
                send_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Mode 0 receive
    // ----------------------------------------
    logic rx_req_q;
    logic recv_q;
    logic rx_bit_q;
    logic rx_last_q;
    logic [7:0] rx_shift_q;
    logic rx_finish;

    assign rx_finish = at_s1 && recv_q && rx_last_q;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rx_req_q <= 1'b0;
            recv_q <= 1'b0;
            rx_bit_q <= 1'b1;
            rx_last_q <= 1'b0;
            rx_shift_q <= 8'hff;
            serial_buffer_rx_q <= 8'h00;
        end else begin
            // enabled and done clear starts it
            if (at_s1 && !rx_req_q && !recv_q && !send_q && mode == UBS_MODE0
                && serial_control_reg_q[CTL_RX_EN] && !receive_done_flag_q) begin
                rx_req_q <= 1'b1;
            end
            if (at_s5) begin
                rx_bit_q <= data_sync_q[1];
            end
            if (at_s6 && rx_req_q) begin
                // preset pattern, active from next state
                rx_req_q <= 1'b0;
                rx_shift_q <= RX_INIT_PATTERN;
                recv_q <= 1'b1;
            end else if (at_s6 && recv_q && !rx_last_q) begin
                // left shift, new bit on the right
                rx_shift_q <= {rx_shift_q[6:0], rx_bit_q};
                // zero at the left: last shift loads buffer
                if (!rx_shift_q[7]) begin
                    rx_last_q <= 1'b1;
                    serial_buffer_rx_q <= {rx_shift_q[6:0], rx_bit_q};
                end
            end
            if (rx_finish) begin
                recv_q <= 1'b0;
                rx_last_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Done flags and interrupt; a set wins over a clear
    // ----------------------------------------
    logic sts_clr;

    assign sts_clr = wr_hit(OFS_STATUS);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            transmit_done_flag_q <= 1'b0;
            receive_done_flag_q <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            if (tx_finish) begin
                transmit_done_flag_q <= 1'b1;
            end else if (sts_clr && avs_writedata_in[STS_TX_DONE]) begin
                transmit_done_flag_q <= 1'b0;
            end
            if (rx_finish) begin
                receive_done_flag_q <= 1'b1;
            end else if (sts_clr && avs_writedata_in[STS_RX_DONE]) begin
                receive_done_flag_q <= 1'b0;
            end
            irq_out <= |({receive_done_flag_q, transmit_done_flag_q} & irq_mask_q);
        end
    end

    // ----------------------------------------
    // Pin drive, registered; idle lines rest high
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            port_line_clock_out <= 1'b1;
            port_line_data_out <= 1'b1;
            port_line_data_oe_out <= 1'b0;
        end else begin
            port_line_clock_out <= ~((send_q | recv_q) && state_q >= ST_S3 && state_q <= ST_S5);
            port_line_data_out <= send_q ? tx_shift_q[0] : 1'b1;
            port_line_data_oe_out <= send_q;
        end
    end

    assign avs_readdata_out = readdata_q;
    assign avs_waitrequest_out = waitreq_q;
endmodule

`default_nettype wire

// *** test/ubs_props.sv ***
// Port assertions for the serial rate and mode 0 shift block.
// Assumes a bind onto ubs_uart_baud; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module ubs_props (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic port_line_data_out,
    input wire logic port_line_data_oe_out,
    input wire logic port_line_clock_out,
    input wire logic baud_tick_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // ----------------------------------------
    // Frame counters
    // ----------------------------------------
    logic [7:0] len_q;
    logic [3:0] falls_q;
    // Cleared outside frames: one count per send
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !port_line_data_oe_out) begin
            len_q <= 8'h00;
            falls_q <= 4'h0;
        end else begin
            len_q <= len_q + 8'h01;
            falls_q <= falls_q + {3'h0, $fell(port_line_clock_out)};
        end
    end
    sequence clk_low_s;
        !port_line_clock_out [*3] ##1 port_line_clock_out;
    endsequence
    sequence clk_high_s;
        port_line_clock_out [*3];
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    bus_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("no answer");
    wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait low long");
    read_upper_a: assert property (!avs_waitrequest_out && avs_read_in |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper lanes set");
    reset_idle_a: assert property ($fell(rst_in) |-> avs_waitrequest_out && port_line_data_out
        && !port_line_data_oe_out && port_line_clock_out && !baud_tick_out && !irq_out)
        else $error("not idle");
    clock_low_a: assert property ($fell(port_line_clock_out) |-> clk_low_s)
        else $error("low phase");
    clock_high_a: assert property ($rose(port_line_clock_out) |-> clk_high_s)
        else $error("high phase");
    data_hold_a: assert property (port_line_data_oe_out && !port_line_clock_out |-> $stable(port_line_data_out))
        else $error("data moved");
    send_start_a: assert property ($rose(port_line_data_oe_out) |-> port_line_clock_out)
        else $error("bad start");
    frame_len_a: assert property ($fell(port_line_data_oe_out) |-> len_q == 8'd48 && falls_q == 4'd8)
        else $error("frame length");
    tick_gap_a: assert property (baud_tick_out |=> !baud_tick_out [*5])
        else $error("ticks close");
endmodule
bind ubs_uart_baud ubs_props u_ubs_props (.*);
`default_nettype wire

// *** test/ubs_shift_peer.sv ***
// Model of an external shift register on the mode 0 link.
// Assumes it sees the resolved data line and the shift clock pin.
`timescale 1ns/100ps
`default_nettype none
module ubs_shift_peer (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic line_clock_in,
    input wire logic line_data_in,
    input wire logic line_oe_in,
    input wire logic [7:0] send_byte_in,
    output logic drive_out,
    output logic [7:0] got_byte_out,
    output logic [3:0] got_bits_out
);
    logic clk_prev_q;
    logic oe_prev_q;
    logic last_q;
    logic [3:0] idx_q;
    logic [7:0] idle_q;
    logic rise;
    assign rise = line_clock_in && !clk_prev_q;
    // LSB first, taken at each clock rise
    always_ff @(posedge clk_sys_in) begin
        clk_prev_q <= line_clock_in;
        oe_prev_q <= line_oe_in;
        last_q <= drive_out;
        idle_q <= !line_clock_in ? 8'h00 : idle_q + {7'h0, idle_q != 8'hff};
        if (rst_in || (line_oe_in && !oe_prev_q)) begin
            got_bits_out <= 4'h0;
        end else if (rise && line_oe_in) begin
            got_byte_out <= {line_data_in, got_byte_out[7:1]};
            got_bits_out <= got_bits_out + 4'h1;
        end
    end
    // next bit after each rise; long idle restarts
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || idle_q > 8'd12) begin
            idx_q <= 4'h0;
        end else if (rise && !line_oe_in) begin
            idx_q <= idx_q + 4'h1;
        end
    end
    // Released line toggles: a late sample fails
    assign drive_out = idx_q < 4'h8 ? send_byte_in[3'h7 - idx_q[2:0]] : ~last_q;
endmodule
`default_nettype wire

// *** test/ubs_uart_baud_tb.sv ***
// Self-checking bench for the serial rate and mode 0 shift block.
// Assumes the shift peer model and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
module ubs_uart_baud_tb;
    import ubs_pkg::*;
    typedef struct {logic [7:0] ctl, pwr, tmd, th; int per;} ubs_rate_t;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] avs_address_in = 5'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic timer_count_pin_in = 1'b1;
    logic [7:0] send_byte = 8'h00;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out, port_line_data_out, port_line_data_oe_out, port_line_clock_out, baud_tick_out, irq_out;
    logic peer_drive;
    logic [7:0] got_byte;
    logic [3:0] got_bits;
    wire line_level;
    int num_errors = 0;
    int checks_done = 0;
    int pin_div = 0;
    ubs_rate_t rates [7] = '{'{8'h00, 8'h00, 8'h20, 8'hff, 6}, '{8'h02, 8'h00, 8'h20, 8'hff, 32},
        '{8'h02, 8'h80, 8'h20, 8'hff, 16}, '{8'h41, 8'h00, 8'h20, 8'hff, 192}, '{8'h41, 8'h80, 8'h20, 8'hff, 96},
        '{8'h43, 8'h00, 8'h20, 8'hfe, 384}, '{8'h41, 8'h00, 8'h60, 8'hff, 640}};
    logic [15:0] frames [4] = '{16'ha55a, 16'h0180, 16'h8001, 16'hff00};
    logic [12:0] regs [6] = '{{OFS_SERIAL_CONTROL, 8'h00}, {OFS_POWER_CONTROL, 8'h00}, {OFS_TIMER_MODE, 8'h20},
        {OFS_IRQ_MASK, 8'h00}, {OFS_STATUS, 8'h00}, {OFS_SERIAL_BUFFER, 8'h00}};
    // Data line resolves to whoever holds the enable
    assign line_level = port_line_data_oe_out ? port_line_data_out : peer_drive;
    ubs_uart_baud u_ubs_uart_baud (.clk_sys_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .port_line_data_in(line_level), .port_line_data_out, .port_line_data_oe_out, .port_line_clock_out,
        .timer_count_pin_in, .timer_gate_pin_in(1'b0), .baud_tick_out, .irq_out);
    ubs_shift_peer u_ubs_shift_peer (.clk_sys_in, .rst_in, .line_clock_in(port_line_clock_out),
        .line_data_in(line_level), .line_oe_in(port_line_data_oe_out), .send_byte_in(send_byte),
        .drive_out(peer_drive), .got_byte_out(got_byte), .got_bits_out(got_bits));
    // Clock, and a counter pin falling every 20 clocks
    always #10 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        pin_div <= (pin_div == 9) ? 0 : pin_div + 1;
        if (pin_div == 9) timer_count_pin_in <= ~timer_count_pin_in;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        num_errors++;
        $display("[ERR] %0t wait ran out: %s", $time, what);
        tally_and_finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %0h want %0h", $time, what, got, exp);
        end
    endtask
    // Request held until waitrequest sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_sys_in);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        q = avs_readdata_out[7:0];
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (n >= 40) timeout("bus");
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string what);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, e, what);
    endtask
    task automatic wait_sts(input int b);
        logic [7:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 8'h00, q);
            n++;
        end while (q[b] !== 1'b1 && n < 200);
        if (n >= 200) timeout("status");
    endtask
    // Third gap is free of earlier changes
    task automatic tick_period(output int p);
        int n;
        n = 0;
        repeat (3) begin
            p = 0;
            do begin
                @(posedge clk_sys_in);
                p++;
                n++;
            end while (baud_tick_out !== 1'b1 && n < 3000);
        end
        if (n >= 3000) timeout("tick");
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int p;
        int c;
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (rates[i]) begin
            wr(OFS_TIMER_MODE, rates[i].tmd);
            wr(OFS_TIMER_HIGH, rates[i].th);
            wr(OFS_TIMER_LOW, rates[i].th);
            wr(OFS_POWER_CONTROL, rates[i].pwr);
            wr(OFS_SERIAL_CONTROL, rates[i].ctl);
            tick_period(p);
            check(p, rates[i].per, "tick period");
            $display("rate row %0d done", i);
        end
        foreach (frames[i]) begin
            wr(OFS_SERIAL_CONTROL, 8'h00);
            wr(OFS_IRQ_MASK, 8'h01);
            send_byte <= frames[i][7:0];
            wr(OFS_SERIAL_BUFFER, frames[i][15:8]);
            c = 0;
            do begin @(posedge clk_sys_in); c++; end while (port_line_data_oe_out !== 1'b1 && c < 100);
            do begin @(posedge clk_sys_in); c++; end while (port_line_data_oe_out !== 1'b0 && c < 100);
            check(c >= 54 && c <= 63, 1, "send length");
            wait_sts(STS_TX_DONE);
            check(got_byte, frames[i][15:8], "sent byte");
            check(got_bits, 8, "sent bit count");
            check(irq_out, 1, "irq raised");
            wr(OFS_STATUS, 8'h01);
            wr(OFS_SERIAL_CONTROL, 8'h10);
            wait_sts(STS_RX_DONE);
            check(irq_out, 0, "irq masked");
            wr(OFS_SERIAL_CONTROL, 8'h00);
            rdc(OFS_SERIAL_BUFFER, frames[i][7:0], "received byte");
            wr(OFS_IRQ_MASK, 8'h02);
            repeat (2) @(posedge clk_sys_in);
            check(irq_out, 1, "irq unmasked");
            wr(OFS_STATUS, 8'h02);
            repeat (2) @(posedge clk_sys_in);
            check(irq_out, 0, "irq cleared");
            $display("frame row %0d done", i);
        end
        // Lane off and unmapped writes change nothing
        avs_byteenable_in <= 4'h0;
        wr(OFS_POWER_CONTROL, 8'h80);
        avs_byteenable_in <= 4'hf;
        wr(5'h02, 8'hff);
        rdc(5'h02, 8'h00, "unmapped");
        rdc(OFS_POWER_CONTROL, 8'h00, "lane off write");
        $display("refusal test done");
        // Reset mid-send, then reset values
        wr(OFS_SERIAL_BUFFER, 8'h3c);
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        check(port_line_data_oe_out, 0, "send cut by reset");
        foreach (regs[i]) rdc(regs[i][12:8], regs[i][7:0], "reset value");
        $display("reset test done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
